// *** sleep_wake_pkg.sv ***
package sleep_wake_pkg;
   localparam int unsigned STAB_TIME_NS = 2000;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FORCED_NOP_CYCLES = 2;
   localparam logic [15:0] IRQ_VECTOR = 16'h0004;
   localparam logic RST_POWER_DOWN_FLAG = 1'b1;
   localparam logic RST_TIME_OUT_FLAG = 1'b1;
   localparam int unsigned TMR1_SRC_W = 2;
   localparam logic [1:0] TMR1_SRC_FOSC = 2'h0;
   localparam logic [1:0] TMR1_SRC_LFOSC = 2'h1;
   localparam logic [1:0] TMR1_SRC_EXT = 2'h2;
   localparam logic [1:0] TMR1_SRC_XTAL = 2'h3;

   typedef enum {ST_RUN, ST_SLEEP, ST_STAB, ST_EXEC_NEXT, ST_FORCED_NOP} sleep_state_t;

   typedef struct packed {
      logic master_clear_pin;
      logic master_clear_en;
      logic brownout_reset;
      logic brownout_en;
      logic power_on_reset;
   } reset_src_t;

   typedef struct packed {
      logic run_core_clk;
      logic run_periph_hf;
      logic run_tmr1;
      logic run_adc;
      logic low_freq_osc_en;
      logic regulator_low_power;
      logic pin_hold;
   } power_ctl_t;
endpackage

// *** sync2.sv ***
`timescale 1ns/1ps
module sync2
   import sleep_wake_pkg::*;
#(
   parameter int W = 1
)(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_reg <= '0;
         q_reg <= '0;
      end
      else
      begin
         meta_reg <= d_i;
         q_reg <= meta_reg;
      end
   end

   assign q_o = q_reg;
endmodule

// *** sleep_wake_controller.sv ***
`timescale 1ns/1ps
module sleep_wake_controller
   import sleep_wake_pkg::*;
#(
   parameter int NUM_IRQ = 8,
   parameter int STAB_CNT = STAB_CYCLES,
   parameter int NOP_CNT = FORCED_NOP_CYCLES
)(
   input wire logic core_clk_i,
   input wire logic rst_i,
   // core side, same clock
   input wire logic sleep_exec_i,
   input wire logic global_interrupt_enable_i,
   input wire logic [NUM_IRQ-1:0] irq_enable_i,
   input wire logic [NUM_IRQ-1:0] irq_sleep_capable_i,
   input wire logic [15:0] pc_i,
   // asynchronous event inputs from pins and slow domains
   input wire logic [NUM_IRQ-1:0] irq_flag_i,
   input wire logic watchdog_timeout_i,
   input wire logic master_clear_pin_i,
   input wire logic brownout_reset_i,
   input wire logic power_on_reset_i,
   // configuration
   input wire logic master_clear_en_i,
   input wire logic brownout_en_i,
   input wire logic watchdog_en_i,
   input wire logic watchdog_run_in_sleep_i,
   input wire logic regulator_low_power_select_i,
   input wire logic [TMR1_SRC_W-1:0] tmr1_clk_src_i,
   input wire logic adc_rc_osc_sel_i,
   input wire logic clr_watchdog_i,
   // pins to hold
   input wire logic [7:0] pin_out_i,
   input wire logic [7:0] pin_oe_n_i,
   output logic [7:0] pin_out_o,
   output logic [7:0] pin_oe_n_o,
   // outputs
   output logic core_clk_en_o,
   output logic prefetch_o,
   output logic [15:0] prefetch_addr_o,
   output logic exec_prefetched_o,
   output logic forced_nop_o,
   output logic vector_o,
   output logic [15:0] vector_addr_o,
   output logic watchdog_clear_o,
   output logic watchdog_run_o,
   output logic device_reset_o,
   output logic power_down_flag_o,
   output logic time_out_flag_o,
   output logic asleep_o,
   output power_ctl_t power_ctl_o
);
   //--------------------------------------------------------------
   // input synchronisers
   //--------------------------------------------------------------
   logic [NUM_IRQ-1:0] irq_flag_s;
   logic wdt_to_s;
   reset_src_t rst_src_s;

   sync2 #(.W(NUM_IRQ)) u_sync_irq
   (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .d_i(irq_flag_i),
      .q_o(irq_flag_s)
   );

   sync2 #(.W(6)) u_sync_rst
   (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .d_i({watchdog_timeout_i, master_clear_pin_i, master_clear_en_i,
            brownout_reset_i, brownout_en_i, power_on_reset_i}),
      .q_o({wdt_to_s, rst_src_s})
   );

   //--------------------------------------------------------------
   // decode
   //--------------------------------------------------------------
   sleep_state_t state_reg, state_next;
   logic power_down_flag_reg, power_down_flag_next;
   logic time_out_flag_reg, time_out_flag_next;
   logic [15:0] wake_pc_reg, wake_pc_next;
   logic vector_pend_reg, vector_pend_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [7:0] pin_out_hold_reg;
   logic [7:0] pin_oe_n_hold_reg;
   logic wdt_clear;

   wire logic irq_enabled_any = |(irq_flag_s & irq_enable_i);
   wire logic irq_wake_any = |(irq_flag_s & irq_enable_i & irq_sleep_capable_i);
   wire logic wdt_wake = watchdog_en_i & watchdog_run_in_sleep_i & wdt_to_s;
   wire logic full_reset = (rst_src_s.master_clear_pin & rst_src_s.master_clear_en)
                         | (rst_src_s.brownout_reset & rst_src_s.brownout_en)
                         | rst_src_s.power_on_reset;
   wire logic in_run = (state_reg == ST_RUN);
   wire logic in_sleep = (state_reg == ST_SLEEP);
   // a pending enabled irq with global enable off turns sleep into a no-op
   wire logic sleep_is_nop = ~global_interrupt_enable_i & irq_enabled_any;
   wire logic sleep_enter = in_run & sleep_exec_i & ~sleep_is_nop;
   wire logic wake_event = in_sleep & (irq_wake_any | wdt_wake);
   wire logic wake_by_irq = irq_wake_any;
   wire logic stab_needed = regulator_low_power_select_i;
   wire logic tmr1_slow_src = (tmr1_clk_src_i == TMR1_SRC_LFOSC)
                            | (tmr1_clk_src_i == TMR1_SRC_EXT)
                            | (tmr1_clk_src_i == TMR1_SRC_XTAL);
   wire logic cnt_done = (cnt_reg == 16'h0000);
   wire logic holding = (state_reg == ST_SLEEP) | (state_reg == ST_STAB);

   //--------------------------------------------------------------
   // state machine
   //--------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      wake_pc_next = wake_pc_reg;
      vector_pend_next = vector_pend_reg;
      power_down_flag_next = power_down_flag_reg;
      time_out_flag_next = time_out_flag_reg;
      wdt_clear = clr_watchdog_i;
      case (state_reg)
         ST_RUN:
         begin
            if (sleep_enter)
            begin
               state_next = ST_SLEEP;
               wake_pc_next = pc_i + 16'h0001;
               power_down_flag_next = 1'b0;
               time_out_flag_next = 1'b1;
               wdt_clear = 1'b1;
            end
         end
         ST_SLEEP:
         begin
            if (wake_event)
            begin
               wdt_clear = 1'b1;
               vector_pend_next = wake_by_irq & global_interrupt_enable_i;
               if (stab_needed)
               begin
                  state_next = ST_STAB;
                  cnt_next = 16'(STAB_CNT - 1);
               end
               else
               begin
                  state_next = ST_EXEC_NEXT;
               end
            end
         end
         ST_STAB:
         begin
            if (cnt_done)
            begin
               state_next = ST_EXEC_NEXT;
            end
            else
            begin
               cnt_next = cnt_reg - 16'h0001;
            end
         end
         ST_EXEC_NEXT:
         begin
            if (vector_pend_reg)
            begin
               state_next = ST_FORCED_NOP;
               cnt_next = 16'(NOP_CNT - 1);
            end
            else
            begin
               state_next = ST_RUN;
            end
         end
         ST_FORCED_NOP:
         begin
            if (cnt_done)
            begin
               state_next = ST_RUN;
               vector_pend_next = 1'b0;
            end
            else
            begin
               cnt_next = cnt_reg - 16'h0001;
            end
         end
         default:
         begin
            state_next = ST_RUN;
         end
      endcase
   end

   //--------------------------------------------------------------
   // sequencer registers
   //--------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_reg <= ST_RUN;
         cnt_reg <= 16'h0000;
      end
      else if (full_reset)
      begin
         state_reg <= ST_RUN;
         cnt_reg <= 16'h0000;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   //--------------------------------------------------------------
   // status flags
   //--------------------------------------------------------------
   // only a reset sets them back, so a no-op sleep leaves them untouched
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         power_down_flag_reg <= RST_POWER_DOWN_FLAG;
         time_out_flag_reg <= RST_TIME_OUT_FLAG;
      end
      else if (full_reset)
      begin
         power_down_flag_reg <= RST_POWER_DOWN_FLAG;
         time_out_flag_reg <= RST_TIME_OUT_FLAG;
      end
      else
      begin
         power_down_flag_reg <= power_down_flag_next;
         time_out_flag_reg <= time_out_flag_next;
      end
   end

   //--------------------------------------------------------------
   // wake context
   //--------------------------------------------------------------
   // the prefetched address is kept for the whole sleep
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wake_pc_reg <= 16'h0000;
         vector_pend_reg <= 1'b0;
      end
      else if (full_reset)
      begin
         wake_pc_reg <= 16'h0000;
         vector_pend_reg <= 1'b0;
      end
      else
      begin
         wake_pc_reg <= wake_pc_next;
         vector_pend_reg <= vector_pend_next;
      end
   end

   //--------------------------------------------------------------
   // pin hold
   //--------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pin_out_hold_reg <= 8'h00;
         pin_oe_n_hold_reg <= 8'hff;
      end
      else if (!holding)
      begin
         pin_out_hold_reg <= pin_out_i;
         pin_oe_n_hold_reg <= pin_oe_n_i;
      end
   end

   assign pin_out_o = pin_out_hold_reg;
   assign pin_oe_n_o = pin_oe_n_hold_reg;

   //--------------------------------------------------------------
   // outputs
   //--------------------------------------------------------------
   logic exec_reg;
   logic nop_reg;
   logic vec_reg;
   logic wdt_clr_reg;
   logic dev_rst_reg;

   // pulses that walk the core through the wake sequence
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         exec_reg <= 1'b0;
         nop_reg <= 1'b0;
         vec_reg <= 1'b0;
      end
      else
      begin
         exec_reg <= (state_next == ST_EXEC_NEXT);
         nop_reg <= (state_next == ST_FORCED_NOP);
         vec_reg <= (state_reg == ST_FORCED_NOP) & cnt_done;
      end
   end

   // reset is reported high until the first edge after it ends
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wdt_clr_reg <= 1'b0;
         dev_rst_reg <= 1'b1;
      end
      else
      begin
         wdt_clr_reg <= wdt_clear | full_reset;
         dev_rst_reg <= full_reset;
      end
   end

   assign core_clk_en_o = ~holding;
   assign prefetch_o = sleep_enter;
   // held from entry so the core fetches the right word on wake
   assign prefetch_addr_o = wake_pc_reg;
   assign exec_prefetched_o = exec_reg;
   assign forced_nop_o = nop_reg;
   assign vector_o = vec_reg;
   assign vector_addr_o = IRQ_VECTOR;
   assign watchdog_clear_o = wdt_clr_reg;
   assign watchdog_run_o = watchdog_en_i & (~holding | watchdog_run_in_sleep_i);
   assign device_reset_o = dev_rst_reg;
   assign power_down_flag_o = power_down_flag_reg;
   assign time_out_flag_o = time_out_flag_reg;
   assign asleep_o = holding;

   assign power_ctl_o.run_core_clk = ~holding;
   assign power_ctl_o.run_periph_hf = ~holding;
   assign power_ctl_o.run_tmr1 = ~holding | tmr1_slow_src;
   assign power_ctl_o.run_adc = ~holding | adc_rc_osc_sel_i;
   assign power_ctl_o.low_freq_osc_en = 1'b1;
   assign power_ctl_o.regulator_low_power = in_sleep & regulator_low_power_select_i;
   assign power_ctl_o.pin_hold = holding;
endmodule

// *** sleep_wake_checker.sv ***
`timescale 1ns/1ps
module sleep_wake_checker
   import sleep_wake_pkg::*;
#(
   parameter int NUM_IRQ = 8,
   parameter int STAB_CNT = STAB_CYCLES,
   parameter int NOP_CNT = FORCED_NOP_CYCLES
)(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [15:0] pc_i,
   input wire logic regulator_low_power_select_i,
   input wire logic [7:0] pin_out_o,
   input wire logic [7:0] pin_oe_n_o,
   input wire logic core_clk_en_o,
   input wire logic prefetch_o,
   input wire logic [15:0] prefetch_addr_o,
   input wire logic exec_prefetched_o,
   input wire logic forced_nop_o,
   input wire logic vector_o,
   input wire logic watchdog_clear_o,
   input wire logic device_reset_o,
   input wire logic power_down_flag_o,
   input wire logic time_out_flag_o,
   input wire logic asleep_o
);
   // ------------------------------
   // sleep entry and wake sequences
   // ------------------------------
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence entry_seen;
      asleep_o && !core_clk_en_o && !power_down_flag_o && time_out_flag_o && watchdog_clear_o;
   endsequence
   sequence nop_run;
      forced_nop_o [*2] ##1 vector_o;
   endsequence
   sequence stab_run;
      !exec_prefetched_o [*3] ##[0:3] exec_prefetched_o;
   endsequence
   chk_prefetch_addr: assert property (prefetch_o |=> prefetch_addr_o == $past(pc_i) + 16'h0001)
      else $error("prefetch address wrong");
   chk_entry_flags: assert property (prefetch_o |=> entry_seen)
      else $error("sleep entry wrong");
   chk_clk_stop: assert property (asleep_o |-> !core_clk_en_o)
      else $error("core clock runs asleep");
   chk_sleep_cause: assert property ($rose(asleep_o) |-> $past(prefetch_o))
      else $error("sleep without instruction");
   chk_pin_hold: assert property (asleep_o && $past(asleep_o) |-> $stable({pin_out_o, pin_oe_n_o}))
      else $error("pins moved asleep");
   chk_vector_nops: assert property ($rose(forced_nop_o) |-> nop_run)
      else $error("forced nop run wrong");
   chk_flag_cause: assert property ($changed(power_down_flag_o) && !device_reset_o |-> $past(prefetch_o))
      else $error("flag changed without sleep");
   chk_wake_wdclr: assert property (exec_prefetched_o && !regulator_low_power_select_i |-> watchdog_clear_o)
      else $error("no watchdog clear at wake");
   chk_stab_delay: assert property (
      watchdog_clear_o && !core_clk_en_o && regulator_low_power_select_i && !$past(prefetch_o)
      && !device_reset_o |-> stab_run)
      else $error("stabilisation delay wrong");
endmodule
bind sleep_wake_controller sleep_wake_checker #(.NUM_IRQ(NUM_IRQ), .STAB_CNT(STAB_CNT), .NOP_CNT(NOP_CNT)) chk (.*);

// *** core_model.sv ***
`timescale 1ns/1ps
module core_model (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic core_clk_en_i,
   input wire logic sleep_req_i,
   output logic sleep_exec_o,
   output logic [15:0] pc_o
);
   // ------------------------------
   // core issues sleep only while clocked
   // ------------------------------
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sleep_exec_o <= 1'b0;
         pc_o <= 16'h0000;
      end
      else if (core_clk_en_i)
      begin
         sleep_exec_o <= sleep_req_i && !sleep_exec_o;
         pc_o <= pc_o + 16'h0001;
      end
      else
         sleep_exec_o <= 1'b0;
   end
endmodule

// *** sleep_wake_controller_tb.sv ***
`timescale 1ns/1ps
module sleep_wake_controller_tb;
   import sleep_wake_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic sleep_req = 1'b0;
   logic sleep_exec_i, global_interrupt_enable_i, watchdog_timeout_i, master_clear_pin_i, brownout_reset_i;
   logic master_clear_en_i, watchdog_en_i, watchdog_run_in_sleep_i, regulator_low_power_select_i;
   logic adc_rc_osc_sel_i, clr_watchdog_i, core_clk_en_o, prefetch_o, exec_prefetched_o, forced_nop_o;
   logic vector_o, watchdog_clear_o, watchdog_run_o, device_reset_o, power_down_flag_o, time_out_flag_o, asleep_o;
   logic [1:0] tmr1_clk_src_i;
   logic [7:0] irq_enable_i, irq_sleep_capable_i, irq_flag_i, pin_out_i, pin_oe_n_i, pin_out_o, pin_oe_n_o;
   logic [15:0] pc_i, prefetch_addr_o, vector_addr_o, held, pc_exp;
   power_ctl_t power_ctl_o;
   logic power_on_reset_i, brownout_en_i;
   int failures = 0;
   int cmp_count = 0;
   int seed = 76725;
   int nops, vecs, clrs;

   always #5 core_clk_i = ~core_clk_i;

   sleep_wake_controller #(.STAB_CNT(4)) DUT (.*);
   core_model core (.core_clk_i(core_clk_i), .rst_i(rst_i), .core_clk_en_i(core_clk_en_o),
      .sleep_req_i(sleep_req), .sleep_exec_o(sleep_exec_i), .pc_o(pc_i));

   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [15:0] nop_exp(input logic global_interrupt_enable);
      return global_interrupt_enable ? 16'(FORCED_NOP_CYCLES) : 16'h0000;
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic enter_sleep;
      sleep_req = 1'b1;
      tick(1);
      sleep_req = 1'b0;
   endtask
   task automatic await_wake;
      int n;
      n = 0;
      {clrs, nops, vecs} = '0;
      while (exec_prefetched_o !== 1'b1 && n < 40)
      begin
         clrs += (watchdog_clear_o === 1'b1);
         tick(1);
         n++;
      end
      clrs += (watchdog_clear_o === 1'b1);
      check("wake seen", n < 40, 1'b1);
      repeat (5)
      begin
         tick(1);
         nops += (forced_nop_o === 1'b1);
         vecs += (vector_o === 1'b1);
      end
   endtask

   initial
   begin
      #50000;
      failures++;
      tally_and_finish();
   end

   initial
   begin
      {global_interrupt_enable_i, watchdog_timeout_i, master_clear_pin_i, brownout_reset_i, power_on_reset_i} = 5'h00;
      {regulator_low_power_select_i, adc_rc_osc_sel_i, clr_watchdog_i, tmr1_clk_src_i} = 5'h00;
      {master_clear_en_i, brownout_en_i, watchdog_en_i, watchdog_run_in_sleep_i} = 4'hf;
      {irq_enable_i, irq_flag_i, pin_out_i} = 24'h000000;
      {irq_sleep_capable_i, pin_oe_n_i} = 16'hffff;
      tick(6);
      check("reset out", {device_reset_o, core_clk_en_o, power_down_flag_o, time_out_flag_o}, 4'hf);
      rst_i = 1'b0;
      tick(1);
      check("pd reset", power_down_flag_o, 1'b1);
      {irq_enable_i, irq_flag_i} = 16'h0101;
      tick(3);
      enter_sleep();
      tick(1);
      check("noop state", {asleep_o, power_down_flag_o, time_out_flag_o, watchdog_clear_o}, 4'h6);
      irq_flag_i = 8'h00;
      $display("test noop finished");
      for (int k = 0; k < 4; k++)
      begin
         {regulator_low_power_select_i, global_interrupt_enable_i} = k[1:0];
         {tmr1_clk_src_i, adc_rc_osc_sel_i, watchdog_run_in_sleep_i} = {k[1:0], k[0], 1'b0};
         irq_enable_i = 8'h01 << ($unsigned($random(seed)) % 8);
         {pin_out_i, pin_oe_n_i} = 16'($random(seed));
         tick(3);
         held = {pin_oe_n_i, pin_out_i};
         enter_sleep();
         pc_exp = pc_i + 16'h0001;
         check("prefetch", prefetch_o, 1'b1);
         tick(1);
         check("prefetch addr", prefetch_addr_o, pc_exp);
         check("sleep state", {asleep_o, core_clk_en_o, power_down_flag_o, time_out_flag_o}, 4'h9);
         check("tmr1 adc lfosc", {power_ctl_o.run_tmr1, power_ctl_o.run_adc, power_ctl_o.low_freq_osc_en},
            {k[1:0] != 2'h0, k[0], 1'b1});
         check("reg lp", power_ctl_o.regulator_low_power, k[1]);
         check("wdt paused", watchdog_run_o, 1'b0);
         check("power gates", {power_ctl_o.run_core_clk, power_ctl_o.run_periph_hf, power_ctl_o.pin_hold}, 3'h1);
         {pin_out_i, pin_oe_n_i, irq_flag_i, irq_sleep_capable_i} = {~pin_out_i, ~pin_oe_n_i, 8'hff, ~irq_enable_i};
         tick(5);
         check("masked irq", asleep_o, 1'b1);
         check("pins held", {pin_oe_n_o, pin_out_o}, held);
         irq_sleep_capable_i = 8'hff;
         await_wake();
         check("wake clear", clrs > 0, 1'b1);
         check("forced nops", 16'(nops), nop_exp(k[0]));
         check("vector count", 16'(vecs), 16'(k[0]));
         check("vector addr", vector_addr_o, IRQ_VECTOR);
         check("resume addr", prefetch_addr_o, pc_exp);
         irq_flag_i = 8'h00;
         tick(3);
         $display("test irq wake finished");
      end
      {regulator_low_power_select_i, global_interrupt_enable_i, irq_enable_i, watchdog_run_in_sleep_i} = 11'h001;
      enter_sleep();
      tick(1);
      check("wdt runs", watchdog_run_o, 1'b1);
      watchdog_timeout_i = 1'b1;
      await_wake();
      watchdog_timeout_i = 1'b0;
      check("wdt wake", {device_reset_o, clrs > 0}, 2'h1);
      tick(3);
      $display("test watchdog wake finished");
      for (int j = 0; j < 3; j++)
      begin
         {master_clear_en_i, brownout_en_i} = 2'h0;
         enter_sleep();
         {power_on_reset_i, brownout_reset_i, master_clear_pin_i} = 3'h1 << j;
         tick(5);
         check("reset gate", asleep_o, j != 2);
         {master_clear_en_i, brownout_en_i} = 2'h3;
         tick(5);
         check("full reset", device_reset_o, 1'b1);
         {power_on_reset_i, brownout_reset_i, master_clear_pin_i} = 3'h0;
         tick(5);
         check("after reset", {asleep_o, power_down_flag_o, time_out_flag_o}, 3'h3);
      end
      $display("test full reset finished");
      tally_and_finish();
   end
endmodule
